// *** srm_pkg.sv ***
// Package for the status-reporting block: register selects, bit positions, timing.
// Assumes a single 50 MHz clock domain.
package srm_pkg;
  localparam int unsigned CLK_HZ       = 50000000;
  localparam int unsigned PULSE_MIN_NS = 1000;
  localparam int unsigned PULSE_CYC    = (PULSE_MIN_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned PCNT_W       = 8;

  localparam logic [3:0] SEL_STB  = 4'h0;
  localparam logic [3:0] SEL_SRE  = 4'h1;
  localparam logic [3:0] SEL_ESR  = 4'h2;
  localparam logic [3:0] SEL_ESE  = 4'h3;
  localparam logic [3:0] SEL_CES  = 4'h4;
  localparam logic [3:0] SEL_CEE  = 4'h5;
  localparam logic [3:0] SEL_ICR  = 4'h6;
  localparam logic [3:0] SEL_ISR  = 4'h7;
  localparam logic [3:0] SEL_ISE  = 4'h8;
  localparam logic [3:0] SEL_ADS  = 4'h9;
  localparam logic [3:0] SEL_ADE  = 4'hA;
  localparam logic [3:0] SEL_PSM  = 4'hB;

  localparam int unsigned ESR_OPC_BIT  = 0;
  localparam int unsigned ESR_EXE_BIT  = 4;
  localparam int unsigned STB_INS_BIT  = 0;
  localparam int unsigned STB_ADS_BIT  = 1;
  localparam int unsigned STB_CES_BIT  = 3;
  localparam int unsigned STB_ESB_BIT  = 5;
  localparam logic [7:0]  RST_BYTE     = 8'h00;
  localparam logic [15:0] RST_WORD     = 16'h0000;

  typedef enum logic [2:0] {
    SRM_IDLE  = 3'b001,
    SRM_LATCH = 3'b010,
    SRM_PULSE = 3'b100
  } srm_line_e;
endpackage

// *** srm_event_reg.sv ***
// One sticky event register with clear-on-read, set wins over clear.
// Assumes synchronous set pulses and one clock.
`timescale 1ns/1ps
module srm_event_reg #(
  parameter int W = 16
) (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic         clk_en,
  input  wire logic [W-1:0] set_bits,
  input  wire logic [W-1:0] clr_bits,
  output logic      [W-1:0] value
);
  typedef struct packed {
    logic [W-1:0] ev;
  } srm_ev_s;
  srm_ev_s st_ff;
  srm_ev_s nxt_st;

  always_comb begin
    nxt_st    = st_ff;
    nxt_st.ev = (st_ff.ev & ~clr_bits) | set_bits;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  assign value = st_ff.ev;
endmodule

// *** srm_pulse_gen.sv ***
// Holds the service line low for a minimum count of cycles after a start strobe.
// Assumes start is a one-cycle pulse.
`timescale 1ns/1ps
module srm_pulse_gen #(
  parameter int CW  = srm_pkg::PCNT_W,
  parameter int CYC = srm_pkg::PULSE_CYC
) (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic clk_en,
  input  wire logic start,
  output logic      busy
);
  typedef struct packed {
    logic [CW-1:0] cnt;
  } srm_pg_s;
  srm_pg_s st_ff;
  srm_pg_s nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (start) begin
      nxt_st.cnt = CW'(CYC);
    end else if (st_ff.cnt != '0) begin
      nxt_st.cnt = st_ff.cnt - CW'(1);
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  assign busy = (st_ff.cnt != '0);
endmodule

// *** srm_status_model.sv ***
// Status-reporting model: status byte, event/enable registers and active-low service line.
// Assumes a command decoder drives one-cycle strobes with select, bit and data fields.
`timescale 1ns/1ps
module srm_status_model #(
  parameter int RW = 16,
  parameter int NCH = 4
) (
  input  wire logic           ref_clk,
  input  wire logic           rst,
  input  wire logic           clk_en,
  input  wire logic           cmd_clear_status,
  input  wire logic           cmd_opc_set,
  input  wire logic           cmd_opc_query,
  input  wire logic           cmd_config_reset,
  input  wire logic           cmd_illegal_param,
  input  wire logic           cmd_read,
  input  wire logic           cmd_write,
  input  wire logic [3:0]     cmd_sel,
  input  wire logic           cmd_bit_mode,
  input  wire logic [3:0]     cmd_bit,
  input  wire logic [RW-1:0]  cmd_wdata,
  input  wire logic [7:0]     comm_err_set,
  input  wire logic [7:0]     std_event_set,
  input  wire logic [RW-1:0]  inst_cond_in,
  input  wire logic [NCH-1:0] adc_sample_new,
  output logic                rsp_valid,
  output logic [RW-1:0]       rsp_data,
  output logic                status_n,
  output logic                pulse_status_mode
);
  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic [7:0]     sre;
    logic [7:0]     ese;
    logic [7:0]     cee;
    logic [RW-1:0]  ise;
    logic [NCH-1:0] ade;
    logic [RW-1:0]  icr;
    logic           psm;
    logic [7:0]     stb_prev;
    srm_pkg::srm_line_e line;
    logic           rsp_v;
    logic [RW-1:0]  rsp_d;
    logic           stat_n;
  } srm_st_s;
  srm_st_s st_ff;
  srm_st_s nxt_st;

  logic [7:0]     esr_q;
  logic [7:0]     ces_q;
  logic [RW-1:0]  isr_q;
  logic [NCH-1:0] ads_q;
  logic [7:0]     esr_set;
  logic [7:0]     esr_clr;
  logic [7:0]     ces_clr;
  logic [RW-1:0]  isr_set;
  logic [RW-1:0]  isr_clr;
  logic [NCH-1:0] ads_clr;
  logic [7:0]     stb;
  logic           srq_new;
  logic           pulse_start;
  logic           pulse_busy;
  logic [RW-1:0]  bit_mask;
  logic [RW-1:0]  rd_mask;
  logic           rd_stb_full;

  ////////////////////////////////////////////////////////////////////////////
  // Event registers
  srm_event_reg #(.W(8)) u_esr (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .clk_en   (clk_en),
    .set_bits (esr_set),
    .clr_bits (esr_clr),
    .value    (esr_q)
  );
  srm_event_reg #(.W(8)) u_ces (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .clk_en   (clk_en),
    .set_bits (comm_err_set),
    .clr_bits (ces_clr),
    .value    (ces_q)
  );
  srm_event_reg #(.W(RW)) u_isr (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .clk_en   (clk_en),
    .set_bits (isr_set),
    .clr_bits (isr_clr),
    .value    (isr_q)
  );
  srm_event_reg #(.W(NCH)) u_ads (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .clk_en   (clk_en),
    .set_bits (adc_sample_new),
    .clr_bits (ads_clr),
    .value    (ads_q)
  );

  srm_pulse_gen u_pulse (
    .ref_clk (ref_clk),
    .rst     (rst),
    .clk_en  (clk_en),
    .start   (pulse_start),
    .busy    (pulse_busy)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read masks and event set/clear terms
  always_comb begin
    bit_mask = RW'(1) << cmd_bit;
    rd_mask  = cmd_bit_mode ? bit_mask : '1;
    rd_stb_full = cmd_read && (cmd_sel == srm_pkg::SEL_STB) && !cmd_bit_mode;
    esr_set = std_event_set;
    esr_set[srm_pkg::ESR_EXE_BIT] = std_event_set[srm_pkg::ESR_EXE_BIT] | cmd_illegal_param;
    esr_set[srm_pkg::ESR_OPC_BIT] = std_event_set[srm_pkg::ESR_OPC_BIT] | cmd_opc_set;
    esr_clr = {8{cmd_clear_status}};
    ces_clr = {8{cmd_clear_status}};
    isr_clr = {RW{cmd_clear_status}};
    ads_clr = '0;
    if (cmd_read && (cmd_sel == srm_pkg::SEL_ESR)) begin
      esr_clr = esr_clr | rd_mask[7:0];
    end
    if (cmd_read && (cmd_sel == srm_pkg::SEL_CES)) begin
      ces_clr = ces_clr | rd_mask[7:0];
    end
    if (cmd_read && (cmd_sel == srm_pkg::SEL_ISR)) begin
      isr_clr = isr_clr | rd_mask;
    end
    if (cmd_read && (cmd_sel == srm_pkg::SEL_ADS)) begin
      ads_clr = rd_mask[NCH-1:0];
    end
    isr_set = inst_cond_in & ~st_ff.icr;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status byte summary and service request detection
  always_comb begin
    stb = srm_pkg::RST_BYTE;
    stb[srm_pkg::STB_INS_BIT] = |(isr_q & st_ff.ise);
    stb[srm_pkg::STB_ADS_BIT] = |(ads_q & st_ff.ade);
    stb[srm_pkg::STB_CES_BIT] = |(ces_q & st_ff.cee);
    stb[srm_pkg::STB_ESB_BIT] = |(esr_q & st_ff.ese);
    srq_new = |(stb & ~st_ff.stb_prev & st_ff.sre);
    pulse_start = srq_new && st_ff.psm;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state: enables, mode, line, responses
  always_comb begin
    nxt_st          = st_ff;
    nxt_st.icr      = inst_cond_in;
    nxt_st.stb_prev = stb;
    nxt_st.rsp_v    = 1'b0;
    // Config reset strobe deliberately touches no status state
    if (cmd_config_reset) begin
      nxt_st.rsp_v = 1'b0;
    end
    if (cmd_write) begin
      case (cmd_sel)
        srm_pkg::SEL_SRE: begin
          nxt_st.sre = cmd_bit_mode ? ((st_ff.sre & ~bit_mask[7:0]) |
                       ({8{cmd_wdata[0]}} & bit_mask[7:0])) : cmd_wdata[7:0];
        end
        srm_pkg::SEL_ESE: begin
          nxt_st.ese = cmd_bit_mode ? ((st_ff.ese & ~bit_mask[7:0]) |
                       ({8{cmd_wdata[0]}} & bit_mask[7:0])) : cmd_wdata[7:0];
        end
        srm_pkg::SEL_CEE: begin
          nxt_st.cee = cmd_bit_mode ? ((st_ff.cee & ~bit_mask[7:0]) |
                       ({8{cmd_wdata[0]}} & bit_mask[7:0])) : cmd_wdata[7:0];
        end
        srm_pkg::SEL_ISE: begin
          nxt_st.ise = cmd_bit_mode ? ((st_ff.ise & ~bit_mask) |
                       ({RW{cmd_wdata[0]}} & bit_mask)) : cmd_wdata;
        end
        srm_pkg::SEL_ADE: begin
          nxt_st.ade = cmd_bit_mode ? ((st_ff.ade & ~bit_mask[NCH-1:0]) |
                       ({NCH{cmd_wdata[0]}} & bit_mask[NCH-1:0])) : cmd_wdata[NCH-1:0];
        end
        srm_pkg::SEL_PSM: begin
          nxt_st.psm = cmd_wdata[0];
        end
        default: begin
          nxt_st.psm = st_ff.psm;
        end
      endcase
    end
    if (cmd_read) begin
      nxt_st.rsp_v = 1'b1;
      case (cmd_sel)
        srm_pkg::SEL_STB: nxt_st.rsp_d = RW'(stb);
        srm_pkg::SEL_SRE: nxt_st.rsp_d = RW'(st_ff.sre);
        srm_pkg::SEL_ESR: nxt_st.rsp_d = RW'(esr_q);
        srm_pkg::SEL_ESE: nxt_st.rsp_d = RW'(st_ff.ese);
        srm_pkg::SEL_CES: nxt_st.rsp_d = RW'(ces_q);
        srm_pkg::SEL_CEE: nxt_st.rsp_d = RW'(st_ff.cee);
        srm_pkg::SEL_ICR: nxt_st.rsp_d = st_ff.icr;
        srm_pkg::SEL_ISR: nxt_st.rsp_d = isr_q;
        srm_pkg::SEL_ISE: nxt_st.rsp_d = st_ff.ise;
        srm_pkg::SEL_ADS: nxt_st.rsp_d = RW'(ads_q);
        srm_pkg::SEL_ADE: nxt_st.rsp_d = RW'(st_ff.ade);
        srm_pkg::SEL_PSM: nxt_st.rsp_d = RW'(st_ff.psm);
        default:          nxt_st.rsp_d = srm_pkg::RST_WORD;
      endcase
      if (cmd_bit_mode) begin
        nxt_st.rsp_d = RW'(nxt_st.rsp_d[cmd_bit]);
      end
    end
    if (cmd_opc_query) begin
      nxt_st.rsp_v = 1'b1;
      nxt_st.rsp_d = RW'(1);
    end
    case (st_ff.line)
      srm_pkg::SRM_IDLE: begin
        if (srq_new && st_ff.psm) begin
          nxt_st.line = srm_pkg::SRM_PULSE;
        end else if (srq_new) begin
          nxt_st.line = srm_pkg::SRM_LATCH;
        end
      end
      srm_pkg::SRM_LATCH: begin
        if (rd_stb_full) begin
          nxt_st.line = srm_pkg::SRM_IDLE;
        end
      end
      srm_pkg::SRM_PULSE: begin
        if (!pulse_busy && !pulse_start) begin
          nxt_st.line = srm_pkg::SRM_IDLE;
        end
      end
      default: begin
        nxt_st.line = srm_pkg::SRM_IDLE;
      end
    endcase
    if (rd_stb_full && (nxt_st.line == srm_pkg::SRM_LATCH)) begin
      nxt_st.line = srm_pkg::SRM_IDLE;
    end
    nxt_st.stat_n = (nxt_st.line == srm_pkg::SRM_IDLE);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_ff        <= '0;
      st_ff.line   <= srm_pkg::SRM_IDLE;
      st_ff.psm    <= 1'b0;
      st_ff.stat_n <= 1'b1;
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  assign rsp_valid         = st_ff.rsp_v;
  assign rsp_data          = st_ff.rsp_d;
  assign status_n          = st_ff.stat_n;
  assign pulse_status_mode = st_ff.psm;
endmodule

// *** srm_status_model_sva.sv ***
// Port checker for the status-reporting block.
// Assumes one clock, async active-high reset.
`timescale 1ns/1ps
module srm_status_model_sva #(
  parameter int RW  = 16,
  parameter int NCH = 4
) (
  input wire logic           ref_clk,
  input wire logic           rst,
  input wire logic           clk_en,
  input wire logic           cmd_opc_query,
  input wire logic           cmd_read,
  input wire logic           cmd_write,
  input wire logic [3:0]     cmd_sel,
  input wire logic           cmd_bit_mode,
  input wire logic [RW-1:0]  cmd_wdata,
  input wire logic           rsp_valid,
  input wire logic [RW-1:0]  rsp_data,
  input wire logic           status_n,
  input wire logic           pulse_status_mode
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [7:0] low_ff;
  logic       w0;
  logic       stb_rd;
  assign w0 = cmd_wdata[0];
  assign stb_rd = clk_en && cmd_read && cmd_sel == srm_pkg::SEL_STB && !cmd_bit_mode;
  // Cycles the service line has been low
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) low_ff <= 8'h00;
    else if (status_n) low_ff <= 8'h00;
    else if (low_ff != 8'hFF) low_ff <= low_ff + 8'h01;
  end
  ////////////////////////////////////////////////////////////////////////////////
  property p_ans;
    clk_en && (cmd_read || cmd_opc_query) |=> rsp_valid;
  endproperty
  a_ans: assert property (p_ans) else $error("no answer");
  property p_quiet;
    !(clk_en && (cmd_read || cmd_opc_query)) |=> !rsp_valid && $stable(rsp_data);
  endproperty
  a_quiet: assert property (p_quiet) else $error("stray answer");
  property p_opc;
    clk_en && cmd_opc_query && !cmd_read |=> rsp_data == RW'(1);
  endproperty
  a_opc: assert property (p_opc) else $error("opc answer");
  property p_rel;
    stb_rd |=> status_n;
  endproperty
  a_rel: assert property (p_rel) else $error("line kept");
  property p_latch;
    !pulse_status_mode && !status_n && !stb_rd && !(clk_en && cmd_write) |=> !status_n;
  endproperty
  a_latch: assert property (p_latch) else $error("latch lost");
  property p_pmin;
    $rose(status_n) && pulse_status_mode |-> low_ff >= srm_pkg::PULSE_CYC;
  endproperty
  a_pmin: assert property (p_pmin) else $error("pulse short");
  property p_pmax;
    pulse_status_mode && !status_n |-> low_ff < 8'h3C;
  endproperty
  a_pmax: assert property (p_pmax) else $error("pulse long");
  property p_mode;
    clk_en && cmd_write && cmd_sel == srm_pkg::SEL_PSM && !cmd_bit_mode
      |=> pulse_status_mode == $past(w0);
  endproperty
  a_mode: assert property (p_mode) else $error("mode write");
  property p_hold;
    !(clk_en && cmd_write) |=> $stable(pulse_status_mode);
  endproperty
  a_hold: assert property (p_hold) else $error("mode moved");
endmodule
bind srm_status_model srm_status_model_sva #(.RW(RW), .NCH(NCH)) u_srm_status_model_sva (
  .ref_clk, .rst, .clk_en, .cmd_opc_query, .cmd_read, .cmd_write, .cmd_sel,
  .cmd_bit_mode, .cmd_wdata, .rsp_valid, .rsp_data, .status_n, .pulse_status_mode);

// *** srm_host_model.sv ***
// Host side: issues one command strobe at a time.
// Assumes the bench samples answers after each task.
`timescale 1ns/1ps
module srm_host_model #(
  parameter int RW = 16
) (
  input  wire logic          ref_clk,
  output logic               cmd_read,
  output logic               cmd_write,
  output logic [3:0]         cmd_sel,
  output logic               cmd_bit_mode,
  output logic [3:0]         cmd_bit,
  output logic [RW-1:0]      cmd_wdata,
  output logic [4:0]         cmd_misc
);
  initial begin
    {cmd_read, cmd_write, cmd_sel, cmd_bit_mode, cmd_bit, cmd_misc} = '0;
    cmd_wdata = '0;
  end
  // Read or write strobe; idle select and data fields show inverted values
  task automatic put(input logic r, input logic w, input logic [3:0] s, input logic m,
                     input logic [3:0] b, input logic [RW-1:0] d);
    @(posedge ref_clk);
    cmd_read <= r;
    cmd_write <= w;
    cmd_sel <= s;
    cmd_bit_mode <= m;
    cmd_bit <= b;
    cmd_wdata <= d;
    @(posedge ref_clk);
    cmd_read <= 1'b0;
    cmd_write <= 1'b0;
    cmd_sel <= ~s;
    cmd_wdata <= ~d;
    #1;
  endtask
  // Order: clear, opc set, opc query, config reset, illegal value
  task automatic fire(input int i);
    @(posedge ref_clk);
    cmd_misc[i] <= 1'b1;
    @(posedge ref_clk);
    cmd_misc <= 5'h00;
    #1;
  endtask
endmodule

// *** srm_status_model_tb.sv ***
// Self-checking bench for the status-reporting block.
// Assumes the host model and checker files are compiled first.
`timescale 1ns/1ps
module srm_status_model_tb;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        clk_en = 1'b1;
  logic [7:0]  comm_err_set = 8'h00;
  logic [7:0]  std_event_set = 8'h00;
  logic [15:0] inst_cond_in = 16'h0000;
  logic [3:0]  adc_sample_new = 4'h0;
  logic        cmd_read, cmd_write, cmd_bit_mode, rsp_valid, status_n, pulse_status_mode;
  logic [3:0]  cmd_sel, cmd_bit;
  logic [15:0] cmd_wdata, rsp_data;
  logic [4:0]  cmd_misc;
  int          num_errors = 0;
  int          cmp_count = 0;
  always #10 ref_clk = ~ref_clk;
  srm_host_model u_host (.ref_clk, .cmd_read, .cmd_write, .cmd_sel, .cmd_bit_mode,
    .cmd_bit, .cmd_wdata, .cmd_misc);
  srm_status_model u_srm_status_model (.ref_clk, .rst, .clk_en,
    .cmd_clear_status(cmd_misc[0]), .cmd_opc_set(cmd_misc[1]), .cmd_opc_query(cmd_misc[2]),
    .cmd_config_reset(cmd_misc[3]), .cmd_illegal_param(cmd_misc[4]), .cmd_read, .cmd_write,
    .cmd_sel, .cmd_bit_mode, .cmd_bit, .cmd_wdata, .comm_err_set, .std_event_set,
    .inst_cond_in, .adc_sample_new, .rsp_valid, .rsp_data, .status_n, .pulse_status_mode);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    if (num_errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic rdc(input string n, input logic [3:0] s, input logic m, input logic [3:0] b,
                     input logic [15:0] e);
    u_host.put(1'b1, 1'b0, s, m, b, 16'h0000);
    chk(n, 16'h0001, {15'h0000, rsp_valid});
    chk(n, e, rsp_data);
  endtask
  task automatic wlow();
    int n = 0;
    while (status_n !== 1'b0 && n < 20) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk("line low", 16'h0000, {15'h0000, status_n});
    if (n == 20) test_done();
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic s_enables();
    logic [3:0] s [5] = '{srm_pkg::SEL_SRE, srm_pkg::SEL_ESE, srm_pkg::SEL_CEE,
                          srm_pkg::SEL_ISE, srm_pkg::SEL_ADE};
    foreach (s[i]) begin
      u_host.put(1'b0, 1'b1, s[i], 1'b0, 4'h0, 16'h0005);
      u_host.put(1'b0, 1'b1, s[i], 1'b1, 4'h1, 16'h0001);
      rdc("enable", s[i], 1'b0, 4'h0, 16'h0007);
      rdc("enable bit", s[i], 1'b1, 4'h3, 16'h0000);
      u_host.put(1'b0, 1'b1, s[i], 1'b0, 4'h0, 16'h0000);
    end
  endtask
  task automatic s_esr();
    u_host.fire(4);
    rdc("esr bit4", srm_pkg::SEL_ESR, 1'b1, 4'h4, 16'h0001);
    u_host.fire(4);
    u_host.fire(1);
    rdc("esr bit0", srm_pkg::SEL_ESR, 1'b1, 4'h0, 16'h0001);
    rdc("esr rest", srm_pkg::SEL_ESR, 1'b0, 4'h0, 16'h0010);
    rdc("esr empty", srm_pkg::SEL_ESR, 1'b0, 4'h0, 16'h0000);
    u_host.fire(1);
    u_host.fire(2);
    chk("opc answer", 16'h0001, rsp_data);
    rdc("esr opc", srm_pkg::SEL_ESR, 1'b0, 4'h0, 16'h0001);
  endtask
  task automatic s_events();
    @(posedge ref_clk) comm_err_set <= 8'h05;
    @(posedge ref_clk) comm_err_set <= 8'h00;
    rdc("ces bit2", srm_pkg::SEL_CES, 1'b1, 4'h2, 16'h0001);
    rdc("ces rest", srm_pkg::SEL_CES, 1'b0, 4'h0, 16'h0001);
    rdc("ces empty", srm_pkg::SEL_CES, 1'b0, 4'h0, 16'h0000);
    @(posedge ref_clk) inst_cond_in <= 16'h0003;
    @(posedge ref_clk) adc_sample_new <= 4'h4;
    @(posedge ref_clk) adc_sample_new <= 4'h0;
    rdc("icr bit", srm_pkg::SEL_ICR, 1'b1, 4'h1, 16'h0001);
    rdc("icr", srm_pkg::SEL_ICR, 1'b0, 4'h0, 16'h0003);
    rdc("isr", srm_pkg::SEL_ISR, 1'b0, 4'h0, 16'h0003);
    rdc("ads", srm_pkg::SEL_ADS, 1'b0, 4'h0, 16'h0004);
    @(posedge ref_clk) inst_cond_in <= 16'h0010;
    @(posedge ref_clk) comm_err_set <= 8'h02;
    @(posedge ref_clk) comm_err_set <= 8'h00;
    u_host.fire(4);
    u_host.fire(0);
    rdc("esr cls", srm_pkg::SEL_ESR, 1'b0, 4'h0, 16'h0000);
    rdc("ces cls", srm_pkg::SEL_CES, 1'b0, 4'h0, 16'h0000);
    rdc("isr cls", srm_pkg::SEL_ISR, 1'b0, 4'h0, 16'h0000);
    rdc("icr live", srm_pkg::SEL_ICR, 1'b0, 4'h0, 16'h0010);
  endtask
  task automatic s_freeze();
    @(posedge ref_clk) clk_en <= 1'b0;
    std_event_set <= 8'hFF;
    adc_sample_new <= 4'hB;
    @(posedge ref_clk) std_event_set <= 8'h00;
    adc_sample_new <= 4'h0;
    u_host.fire(4);
    @(posedge ref_clk) clk_en <= 1'b1;
    rdc("esr frozen", srm_pkg::SEL_ESR, 1'b0, 4'h0, 16'h0000);
    rdc("ads frozen", srm_pkg::SEL_ADS, 1'b0, 4'h0, 16'h0000);
    @(posedge ref_clk) std_event_set <= 8'hFF;
    adc_sample_new <= 4'hB;
    @(posedge ref_clk) std_event_set <= 8'h00;
    adc_sample_new <= 4'h0;
    rdc("esr all", srm_pkg::SEL_ESR, 1'b0, 4'h0, 16'h00FF);
    rdc("esr cleared", srm_pkg::SEL_ESR, 1'b0, 4'h0, 16'h0000);
    rdc("ads all", srm_pkg::SEL_ADS, 1'b0, 4'h0, 16'h000B);
  endtask
  task automatic s_service();
    int n = 0;
    u_host.put(1'b0, 1'b1, srm_pkg::SEL_SRE, 1'b1, 4'h5, 16'h0001);
    u_host.put(1'b0, 1'b1, srm_pkg::SEL_ESE, 1'b0, 4'h0, 16'h0010);
    u_host.fire(4);
    wlow();
    rdc("stb bit5", srm_pkg::SEL_STB, 1'b1, 4'h5, 16'h0001);
    u_host.fire(3);
    chk("line held", 16'h0000, {15'h0000, status_n});
    rdc("stb", srm_pkg::SEL_STB, 1'b0, 4'h0, 16'h0020);
    chk("line freed", 16'h0001, {15'h0000, status_n});
    u_host.fire(0);
    u_host.put(1'b0, 1'b1, srm_pkg::SEL_PSM, 1'b0, 4'h0, 16'h0001);
    rdc("mode", srm_pkg::SEL_PSM, 1'b0, 4'h0, 16'h0001);
    chk("mode pin", 16'h0001, {15'h0000, pulse_status_mode});
    u_host.fire(4);
    wlow();
    while (status_n === 1'b0 && n < 100) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk("pulse ok", 16'h0001, {15'h0000, n >= 50 && n < 60});
    if (n == 100) test_done();
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    #1;
    chk("idle line", 16'h0001, {15'h0000, status_n});
    rdc("mode off", srm_pkg::SEL_PSM, 1'b0, 4'h0, 16'h0000);
    chk("mode pin off", 16'h0000, {15'h0000, pulse_status_mode});
    s_enables();
    s_esr();
    s_events();
    s_freeze();
    s_service();
    test_done();
  end
endmodule
